/* File: hw/decoder_params.svh */
// shared constants for the fourteen-bit instruction decoder
// Contract
// - destination bit: zero to accumulator, one to register
// - decrement register, skip next when zero
// - increment register, zero discards fetched instruction
// - literal add and subtract set carry, half-carry, zero
// - register or, and update zero flag only
// - rotates go through carry, touch carry only
// - bit clear, set, test-skip clear, test-skip set
// - program counter changes cost two cycles
// - return with literal loads accumulator, two cycles
// - standby and watchdog clear set expiry, powerdown flags; standby clears powerdown_flag here, only watchdog clear sets it
// - literal load, no flags, don't-care bits ignored
// - literal or into accumulator, zero flag
// - literal xor into accumulator, zero flag only
// - register xor honours destination, zero flag only
// - port reads take pin levels, not latches
// - timer zero write clears assigned prescaler
// - one instruction cycle is four oscillator periods
`ifndef DECODER_PARAMS_SVH
`define DECODER_PARAMS_SVH

`define OSC_PER_INSN    4
`define PHASE_W         2
`define PHASE_ADDR      2'h0
`define PHASE_COMPUTE   2'h2
`define PHASE_COMMIT    2'h3

`define ACC_RESET       8'h00
`define ADDR_RESET      7'h00
`define TO_RESET        1'b1
`define PD_RESET        1'b1

`define ADDR_TIMER_ZERO 7'h01
`define ADDR_STATUS     7'h03
`define ADDR_PORT_A     7'h05
`define ADDR_PORT_B     7'h06

`define WORD_IDLE       14'h0000
`define WORD_RETURN     14'h0008
`define WORD_INT_RETURN 14'h0009
`define WORD_STANDBY    14'h0063
`define WORD_WDT_CLEAR  14'h0064

`define F_PREFIX        13:12
`define F_OP            11:8
`define F_BITOP         11:10
`define F_JUMP          11
`define F_BIT           9:7
`define F_DEST          7
`define F_FILE          6:0
`define F_LIT           7:0
`define F_TARGET        10:0

`define BIT_C           0
`define BIT_DC          1
`define BIT_Z           2
`define BIT_PD          3
`define BIT_TO          4

`endif

/* File: hw/decoder_pkg.sv */
// types shared by the decoder, its alu and the alu interface
package decoder_pkg;

   typedef enum logic [4:0] {
      alu_pass_b = 5'h00,
      alu_pass_a, alu_add, alu_sub, alu_and, alu_or, alu_xor, alu_com,
      alu_dec, alu_inc, alu_rlc, alu_rrc, alu_swap, alu_clr, alu_bclr,
      alu_bset, alu_bit_test
   } alu_op_t;

   typedef enum logic [1:0] {
      skip_none, skip_zero, skip_bit_clear, skip_bit_set
   } skip_t;

   typedef enum logic [2:0] {
      flow_none, flow_call, flow_jump, flow_ret, flow_int_ret,
      flow_standby, flow_wdt_clear
   } flow_t;

   typedef enum logic [2:0] {
      st_run   = 3'h1,
      st_flush = 3'h2,
      st_sleep = 3'h4
   } exec_state_t;

   typedef struct packed {
      alu_op_t alu_op;
      logic    use_lit;
      logic    to_acc;
      logic    to_file;
      logic    fl_c;
      logic    fl_dc;
      logic    fl_z;
      skip_t   skip;
      flow_t   flow;
   } decoded_t;

endpackage : decoder_pkg

/* File: hw/alu_if.sv */
// operand and result bundle between the decoder and its alu
interface alu_if;
   import decoder_pkg::*;
   alu_op_t    op;
   logic [7:0] a;
   logic [7:0] b;
   logic       carry_in;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic       carry_out;
   logic       half_carry_out;
   logic       zero_out;

   modport core (output op, a, b, carry_in, bit_sel,
                 input  result, carry_out, half_carry_out, zero_out);
   modport unit (input  op, a, b, carry_in, bit_sel,
                 output result, carry_out, half_carry_out, zero_out);
endinterface : alu_if

/* File: hw/exec_alu.sv */
// eight-bit alu with carry, half-carry and zero
module exec_alu
   import decoder_pkg::*;
(
   alu_if.unit bus
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] mask;

   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      mask = 8'h01 << bus.bit_sel;
      bus.result = 8'h00;
      bus.carry_out = bus.carry_in;
      bus.half_carry_out = 1'b0;
      case (bus.op)
         alu_pass_a: bus.result = bus.a;
         alu_add: begin
            sum = {1'b0, bus.a} + {1'b0, bus.b};
            nib = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]};
            bus.result = sum[7:0];
            bus.carry_out = sum[8];
            bus.half_carry_out = nib[4];
         end
         alu_sub: begin
            // operand minus accumulator, carry means no borrow
            sum = {1'b0, bus.b} - {1'b0, bus.a};
            nib = {1'b0, bus.b[3:0]} - {1'b0, bus.a[3:0]};
            bus.result = sum[7:0];
            bus.carry_out = ~sum[8];
            bus.half_carry_out = ~nib[4];
         end
         alu_and:      bus.result = bus.a & bus.b;
         alu_or:       bus.result = bus.a | bus.b;
         alu_xor:      bus.result = bus.a ^ bus.b;
         alu_com:      bus.result = ~bus.b;
         alu_dec:      bus.result = bus.b - 8'h01;
         alu_inc:      bus.result = bus.b + 8'h01;
         alu_rlc: begin
            bus.result = {bus.b[6:0], bus.carry_in};
            bus.carry_out = bus.b[7];
         end
         alu_rrc: begin
            bus.result = {bus.carry_in, bus.b[7:1]};
            bus.carry_out = bus.b[0];
         end
         alu_swap:     bus.result = {bus.b[3:0], bus.b[7:4]};
         alu_clr:      bus.result = 8'h00;
         alu_bclr:     bus.result = bus.b & ~mask;
         alu_bset:     bus.result = bus.b | mask;
         alu_bit_test: bus.result = bus.b & mask;
         default:      bus.result = bus.b;
      endcase
      bus.zero_out = (bus.result == 8'h00);
   end
endmodule : exec_alu

/* File: hw/phase_counter.sv */
// divides the oscillator into the phases of one instruction cycle
`include "decoder_params.svh"
module phase_counter #(
   parameter int PHASES = `OSC_PER_INSN
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   output logic [`PHASE_W-1:0]       phase
);
   localparam logic [`PHASE_W-1:0] LAST = `PHASE_W'(PHASES - 1);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase <= '0;
      end else if (phase == LAST) begin
         phase <= '0;
      end else begin
         phase <= phase + 1'b1;
      end
   end
endmodule : phase_counter

/* File: hw/fourteen_bit_instruction_decoder.sv */
// instruction decoder and executor for the fourteen-bit core
`include "decoder_params.svh"
module fourteen_bit_instruction_decoder
   import decoder_pkg::*;
#(
   parameter int PC_WIDTH    = 13,
   parameter int STACK_DEPTH = 8
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic [13:0]          instr_word,
   input  wire logic [7:0]           data_rdata,
   input  wire logic [4:0]           port_a_pins,
   input  wire logic [7:0]           port_b_pins,
   input  wire logic                 prescaler_to_timer,
   input  wire logic [PC_WIDTH-12:0] page_select,
   input  wire logic                 wake_event,
   output logic [PC_WIDTH-1:0]       prog_addr,
   output logic [6:0]                data_addr,
   output logic [7:0]                data_wdata,
   output logic                      data_we,
   output logic [7:0]                acc,
   output logic                      carry_flag,
   output logic                      half_carry_flag,
   output logic                      zero_flag,
   output logic                      watchdog_expiry_flag,
   output logic                      powerdown_flag,
   output logic                      global_int_enable,
   output logic                      watchdog_clear,
   output logic                      prescaler_clear,
   output logic                      sleeping,
   output logic [4:0]                port_a_latch,
   output logic [7:0]                port_b_latch
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   logic [`PHASE_W-1:0] phase;
   logic [13:0]         instr_reg;
   exec_state_t         state;
   decoded_t            dec;
   logic [7:0]          file_val;
   logic                skip_pending;
   logic                take_skip;
   logic [SP_W-1:0]     sp;
   logic [PC_WIDTH-1:0] stack [STACK_DEPTH];
   logic [PC_WIDTH-1:0] target;
   logic                executing;
   logic                compute;
   logic                commit;

   alu_if alu ();

   ////////////////////////////////////////////////////////////////////
   // phase sequencing and alu

   phase_counter #(
      .PHASES  (`OSC_PER_INSN)
   ) u_phase (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .phase   (phase)
   );

   exec_alu u_alu (
      .bus     (alu)
   );

   assign executing = (state == st_run);
   assign compute   = executing && (phase == `PHASE_COMPUTE);
   assign commit    = (phase == `PHASE_COMMIT);
   assign target    = {page_select, instr_reg[`F_TARGET]};

   assign alu.op       = dec.alu_op;
   assign alu.a        = acc;
   assign alu.b        = dec.use_lit ? instr_reg[`F_LIT] : file_val;
   assign alu.carry_in = carry_flag;
   assign alu.bit_sel  = instr_reg[`F_BIT];

   ////////////////////////////////////////////////////////////////////
   // instruction decode

   always_comb begin
      dec = '{alu_op: alu_pass_b, use_lit: 1'b0, to_acc: 1'b0,
             to_file: 1'b0, fl_c: 1'b0, fl_dc: 1'b0, fl_z: 1'b0,
             skip: skip_none, flow: flow_none};
      case (instr_reg[`F_PREFIX])
         2'h0: begin
            dec.to_acc  = ~instr_reg[`F_DEST];
            dec.to_file = instr_reg[`F_DEST];
            dec.fl_z    = 1'b1;
            case (instr_reg[`F_OP])
               4'h0: begin
                  // move accumulator to register, or a control word
                  dec.alu_op = alu_pass_a;
                  dec.to_acc = 1'b0;
                  dec.fl_z   = 1'b0;
                  case (instr_reg)
                     `WORD_RETURN:     dec.flow = flow_ret;
                     `WORD_INT_RETURN: dec.flow = flow_int_ret;
                     `WORD_STANDBY:    dec.flow = flow_standby;
                     `WORD_WDT_CLEAR:  dec.flow = flow_wdt_clear;
                     default:          dec.flow = flow_none;
                  endcase
               end
               4'h1: dec.alu_op = alu_clr;
               4'h2: begin
                  dec.alu_op = alu_sub;
                  dec.fl_c   = 1'b1;
                  dec.fl_dc  = 1'b1;
               end
               4'h3: dec.alu_op = alu_dec;
               4'h4: dec.alu_op = alu_or;
               4'h5: dec.alu_op = alu_and;
               4'h6: dec.alu_op = alu_xor;
               4'h7: begin
                  dec.alu_op = alu_add;
                  dec.fl_c   = 1'b1;
                  dec.fl_dc  = 1'b1;
               end
               4'h8: dec.alu_op = alu_pass_b;
               4'h9: dec.alu_op = alu_com;
               4'ha: dec.alu_op = alu_inc;
               4'hb: begin
                  dec.alu_op = alu_dec;
                  dec.fl_z   = 1'b0;
                  dec.skip   = skip_zero;
               end
               4'hc: begin
                  dec.alu_op = alu_rrc;
                  dec.fl_z   = 1'b0;
                  dec.fl_c   = 1'b1;
               end
               4'hd: begin
                  dec.alu_op = alu_rlc;
                  dec.fl_z   = 1'b0;
                  dec.fl_c   = 1'b1;
               end
               4'he: begin
                  dec.alu_op = alu_swap;
                  dec.fl_z   = 1'b0;
               end
               default: begin
                  dec.alu_op = alu_inc;
                  dec.fl_z   = 1'b0;
                  dec.skip   = skip_zero;
               end
            endcase
         end
         2'h1: begin
            case (instr_reg[`F_BITOP])
               2'h0: begin
                  dec.alu_op  = alu_bclr;
                  dec.to_file = 1'b1;
               end
               2'h1: begin
                  dec.alu_op  = alu_bset;
                  dec.to_file = 1'b1;
               end
               2'h2: begin
                  dec.alu_op = alu_bit_test;
                  dec.skip   = skip_bit_clear;
               end
               default: begin
                  dec.alu_op = alu_bit_test;
                  dec.skip   = skip_bit_set;
               end
            endcase
         end
         2'h2: begin
            dec.flow = instr_reg[`F_JUMP] ? flow_jump : flow_call;
         end
         default: begin
            dec.use_lit = 1'b1;
            dec.to_acc  = 1'b1;
            dec.fl_z    = 1'b1;
            casez (instr_reg[`F_OP])
               4'b00??: begin
                  dec.alu_op = alu_pass_b;
                  dec.fl_z   = 1'b0;
               end
               4'b01??: begin
                  dec.alu_op = alu_pass_b;
                  dec.fl_z   = 1'b0;
                  dec.flow   = flow_ret;
               end
               4'b1000: dec.alu_op = alu_or;
               4'b1001: dec.alu_op = alu_and;
               4'b1010: dec.alu_op = alu_xor;
               4'b110?: begin
                  dec.alu_op = alu_sub;
                  dec.fl_c   = 1'b1;
                  dec.fl_dc  = 1'b1;
               end
               4'b111?: begin
                  dec.alu_op = alu_add;
                  dec.fl_c   = 1'b1;
                  dec.fl_dc  = 1'b1;
               end
               default: begin
                  dec.to_acc = 1'b0;
                  dec.fl_z   = 1'b0;
               end
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // operand fetch

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_addr <= `ADDR_RESET;
      end else if (phase == `PHASE_ADDR) begin
         data_addr <= instr_reg[`F_FILE];
      end
   end

   always_comb begin
      case (data_addr)
         `ADDR_STATUS: file_val = {3'h0, watchdog_expiry_flag, powerdown_flag,
                                   zero_flag, half_carry_flag, carry_flag};
         `ADDR_PORT_A: file_val = {3'h0, port_a_pins};
         `ADDR_PORT_B: file_val = port_b_pins;
         default:      file_val = data_rdata;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // result write-back to register space

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_we         <= 1'b0;
         data_wdata      <= 8'h00;
         prescaler_clear <= 1'b0;
         port_a_latch    <= 5'h00;
         port_b_latch    <= 8'h00;
      end else begin
         data_we         <= 1'b0;
         prescaler_clear <= 1'b0;
         if (compute && dec.to_file) begin
            data_we    <= 1'b1;
            data_wdata <= alu.result;
            if (data_addr == `ADDR_PORT_A) begin
               port_a_latch <= alu.result[4:0];
            end
            if (data_addr == `ADDR_PORT_B) begin
               port_b_latch <= alu.result;
            end
            if (data_addr == `ADDR_TIMER_ZERO && prescaler_to_timer) begin
               prescaler_clear <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // accumulator

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc <= `ACC_RESET;
      end else if (compute && dec.to_acc) begin
         acc <= alu.result;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // status flags

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         carry_flag           <= 1'b0;
         half_carry_flag      <= 1'b0;
         zero_flag            <= 1'b0;
         watchdog_expiry_flag <= `TO_RESET;
         powerdown_flag       <= `PD_RESET;
         watchdog_clear       <= 1'b0;
      end else begin
         watchdog_clear <= 1'b0;
         if (compute) begin
            // direct status write first, instruction flags override it
            if (dec.to_file && data_addr == `ADDR_STATUS) begin
               carry_flag      <= alu.result[`BIT_C];
               half_carry_flag <= alu.result[`BIT_DC];
               zero_flag       <= alu.result[`BIT_Z];
            end
            if (dec.fl_c) begin
               carry_flag <= alu.carry_out;
            end
            if (dec.fl_dc) begin
               half_carry_flag <= alu.half_carry_out;
            end
            if (dec.fl_z) begin
               zero_flag <= alu.zero_out;
            end
            if (dec.flow == flow_standby) begin
               watchdog_expiry_flag <= 1'b1;
               powerdown_flag       <= 1'b0;
            end
            if (dec.flow == flow_wdt_clear) begin
               watchdog_expiry_flag <= 1'b1;
               powerdown_flag       <= 1'b1;
               watchdog_clear       <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // conditional skip

   always_comb begin
      case (dec.skip)
         skip_zero:      take_skip = alu.zero_out;
         skip_bit_clear: take_skip = alu.zero_out;
         skip_bit_set:   take_skip = ~alu.zero_out;
         default:        take_skip = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         skip_pending <= 1'b0;
      end else if (compute) begin
         skip_pending <= take_skip;
      end else if (commit) begin
         skip_pending <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // return stack

   always_ff @(posedge sys_clk) begin
      if (commit && executing && dec.flow == flow_call) begin
         stack[sp] <= prog_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // program flow, fetch and sequencing

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_addr         <= '0;
         instr_reg         <= `WORD_IDLE;
         sp                <= '0;
         state             <= st_run;
         sleeping          <= 1'b0;
         global_int_enable <= 1'b0;
      end else if (commit) begin
         case (state)
            st_run: begin
               instr_reg <= instr_word;
               prog_addr <= prog_addr + 1'b1;
               if (skip_pending) begin
                  state <= st_flush;
               end
               case (dec.flow)
                  flow_call: begin
                     sp        <= sp + 1'b1;
                     prog_addr <= target;
                     state     <= st_flush;
                  end
                  flow_jump: begin
                     prog_addr <= target;
                     state     <= st_flush;
                  end
                  flow_ret, flow_int_ret: begin
                     sp        <= sp - 1'b1;
                     prog_addr <= stack[sp - 1'b1];
                     state     <= st_flush;
                  end
                  flow_standby: begin
                     state    <= st_sleep;
                     sleeping <= 1'b1;
                  end
                  default: begin
                  end
               endcase
               if (dec.flow == flow_int_ret) begin
                  global_int_enable <= 1'b1;
               end
            end
            st_flush: begin
               // discarded word executes as idle, refetch at new address
               instr_reg <= instr_word;
               prog_addr <= prog_addr + 1'b1;
               state     <= st_run;
            end
            st_sleep: begin
               if (wake_event) begin
                  state    <= st_run;
                  sleeping <= 1'b0;
               end
            end
            default: begin
               state <= st_run;
            end
         endcase
      end
   end

endmodule : fourteen_bit_instruction_decoder

/* File: tb/decoder_properties.sv */
// port-level checks bound onto the instruction decoder
module decoder_properties #(
   parameter int PC_WIDTH = 13
) (
   input wire logic                sys_clk,
   input wire logic                reset_n,
   input wire logic                prescaler_to_timer,
   input wire logic [PC_WIDTH-1:0] prog_addr,
   input wire logic [6:0]          data_addr,
   input wire logic [7:0]          data_wdata,
   input wire logic                data_we,
   input wire logic                watchdog_expiry_flag,
   input wire logic                powerdown_flag,
   input wire logic                watchdog_clear,
   input wire logic                prescaler_clear,
   input wire logic                sleeping,
   input wire logic [7:0]          port_b_latch
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   chk_we_spacing: assert property (data_we |=> !data_we [*3])
      else $error("write strobe closer than one instruction cycle");
   chk_pc_hold: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
      else $error("program address changed inside an instruction cycle");
   chk_wdt_flags: assert property (watchdog_clear |-> watchdog_expiry_flag && powerdown_flag)
      else $error("watchdog clear without both flags set");
   chk_wdt_pulse: assert property (watchdog_clear |=> !watchdog_clear)
      else $error("watchdog clear longer than one clock");
   chk_presc_clr: assert property (prescaler_clear ==
      (data_we && data_addr == 7'h01 && prescaler_to_timer))
      else $error("prescaler clear does not match a timer write");
   chk_port_latch: assert property (data_we && data_addr == 7'h06 |->
      port_b_latch == data_wdata)
      else $error("port latch differs from written value");
   chk_sleep_flags: assert property ($rose(sleeping) |->
      !powerdown_flag && watchdog_expiry_flag)
      else $error("standby entered with wrong flags");
   chk_sleep_pc: assert property (sleeping && $past(sleeping) |-> $stable(prog_addr))
      else $error("program address moved while sleeping");
endmodule : decoder_properties
bind fourteen_bit_instruction_decoder decoder_properties #(.PC_WIDTH(PC_WIDTH)) i_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .prescaler_to_timer(prescaler_to_timer),
   .prog_addr(prog_addr), .data_addr(data_addr), .data_wdata(data_wdata),
   .data_we(data_we), .watchdog_expiry_flag(watchdog_expiry_flag),
   .powerdown_flag(powerdown_flag), .watchdog_clear(watchdog_clear),
   .prescaler_clear(prescaler_clear), .sleeping(sleeping), .port_b_latch(port_b_latch)
);

/* File: tb/prog_mem.sv */
// program memory and data file model facing the decoder
module prog_mem (
   input  wire logic [12:0] prog_addr,
   input  wire logic [6:0]  data_addr,
   input  wire logic [7:0]  fill,
   output logic [13:0]      instr_word,
   output logic [7:0]       data_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] mem [0:31];
   ////////////////////////////////////////
   assign instr_word = mem[prog_addr[4:0]];
   assign data_rdata = (data_addr == 7'h24) ? 8'h01 : fill;
endmodule : prog_mem

/* File: tb/fourteen_bit_instruction_decoder_tb_top.sv */
// self-checking bench for the fourteen-bit instruction decoder
module fourteen_bit_instruction_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk;
   logic        reset_n;
   logic [13:0] instr_word;
   logic [7:0]  data_rdata;
   logic [4:0]  port_a_pins;
   logic [7:0]  port_b_pins;
   logic [12:0] prog_addr;
   logic [6:0]  data_addr;
   logic [7:0]  data_wdata;
   logic        data_we;
   logic        powerdown_flag;
   logic        sleeping;
   logic        presc;
   logic        presc_clr;
   logic [7:0]  acc;
   logic [3:0]  fl;
   logic [7:0]  fill;
   logic [14:0] exp_q [$];
   integer      seed;
   int          errors;
   int          n_checks;
   int          pc;
   logic [7:0]  k1, k2, k3, a1, st;
   logic [8:0]  s;
   logic [2:0]  b;

   fourteen_bit_instruction_decoder i_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .instr_word(instr_word),
      .data_rdata(data_rdata), .port_a_pins(port_a_pins), .port_b_pins(port_b_pins),
      .prescaler_to_timer(presc), .page_select(2'h0), .wake_event(1'b0),
      .prog_addr(prog_addr), .data_addr(data_addr), .data_wdata(data_wdata),
      .data_we(data_we), .acc(acc), .carry_flag(fl[3]), .half_carry_flag(fl[2]),
      .zero_flag(fl[1]), .watchdog_expiry_flag(fl[0]), .powerdown_flag(powerdown_flag),
      .global_int_enable(), .watchdog_clear(), .prescaler_clear(presc_clr), .sleeping(sleeping),
      .port_a_latch(), .port_b_latch()
   );
   prog_mem i_mem (
      .prog_addr(prog_addr), .data_addr(data_addr), .fill(fill),
      .instr_word(instr_word), .data_rdata(data_rdata)
   );
   ////////////////////////////////////////
   task automatic check(input string what, input logic [14:0] seen, input logic [14:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic put(input logic [13:0] w);
      i_mem.mem[pc] = w;
      pc++;
   endtask : put
   task automatic note(input logic [6:0] a, input logic [7:0] d);
      exp_q.push_back({a, d});
   endtask : note
   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (data_we === 1'b1) begin
         check("write", {data_addr, data_wdata}, exp_q.size() ? exp_q.pop_front() : 15'hx);
         if (data_addr == 7'h01) begin
            check("prescaler", {14'h0, presc_clr}, {14'h0, presc});
         end
      end
   end
   initial begin
      seed = 32'h559b;
      errors = 0;
      n_checks = 0;
      pc = 0;
      reset_n = 1'b0;
      k1 = 8'($random(seed));
      k2 = 8'($random(seed));
      k3 = 8'($random(seed));
      b = 3'($random(seed));
      port_a_pins = 5'($random(seed));
      port_b_pins = 8'($random(seed));
      fill = {1'b0, 7'($random(seed))};
      presc = 1'($random(seed));
      a1 = k1 ^ k2;
      s = a1 + k3;
      st = {3'h0, 2'h3, s[7:0] == 8'h00, ({1'b0, a1[3:0]} + k3[3:0]) > 5'h0f, s[8]};
      for (int i = 0; i < 32; i++) begin
         i_mem.mem[i] = 14'h0000;
      end
      put({6'h30, k1});
      put({6'h3a, k2});
      put(14'h00a0);
      note(7'h20, a1);
      put({6'h3e, k3});
      put(14'h00a1);
      note(7'h21, s[7:0]);
      put(14'h0803);
      put(14'h00a2);
      note(7'h22, st);
      put(14'h0fa3);
      note(7'h23, fill + 8'h01);
      put(14'h0ba4);
      note(7'h24, 8'h00);
      put(14'h00a5);
      put({3'h5, 11'(pc + 2)});
      put(14'h00a6);
      put({4'h5, b, 7'h20});
      note(7'h20, fill | (8'h01 << b));
      put(14'h0886);
      note(7'h06, port_b_pins);
      put(14'h0064);
      put(14'h0081);
      note(7'h01, st);
      put(14'h0063);
      repeat (6) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      for (int t = 0; t < 400 && !(exp_q.size() == 0 && sleeping === 1'b1); t++) begin
         @(posedge sys_clk);
      end
      if (exp_q.size() != 0 || sleeping !== 1'b1) begin
         errors++;
      end
      repeat (8) @(posedge sys_clk);
      check("sleep", {13'h0, sleeping, powerdown_flag}, 15'h2);
      check("state", {acc, fl}, {st, st[0], st[1], port_b_pins == 8'h00, 1'b1});
      check("queue", 15'(exp_q.size()), 15'h0);
      finish_test();
   end
endmodule : fourteen_bit_instruction_decoder_tb_top
